// ==== crc_pkg.sv ====
// Package with register offsets, field positions and reset values of the CRC generator.
// Assumes a 32-bit classic Wishbone slave port with word-aligned registers.
package crc_pkg;
  localparam logic [3:0] CONTROL_OFFSET   = 4'h0;
  localparam logic [3:0] POLY_OFFSET      = 4'h4;
  localparam logic [3:0] DATA_OFFSET      = 4'h8;
  localparam int         STOP_IDLE_BIT    = 13;
  localparam int         COUNT_LSB        = 8;
  localparam int         COUNT_MSB        = 12;
  localparam int         FULL_BIT         = 7;
  localparam int         EMPTY_BIT        = 6;
  localparam int         RUN_BIT          = 4;
  localparam int         LEN_MSB          = 3;
  localparam int         WIDE_LEN_LIMIT   = 7;
  localparam int         DEPTH_NARROW     = 16;
  localparam int         DEPTH_WIDE       = 8;
  localparam logic [15:0] CONTROL_RESET   = 16'h0040;
  localparam logic [15:0] POLY_RESET      = 16'h0000;
  localparam logic [15:0] POLY_MASK       = 16'hFFFE;
endpackage

// ==== crc_lfsr.sv ====
// Serial CRC remainder register of programmable length.
// Assumes one data bit per shift pulse, most significant bit of each word first.
`timescale 1ns/1ps
module crc_lfsr #(
  parameter int WIDTH = 16
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             shift_i,
  input  wire logic             bit_i,
  input  wire logic [3:0]       len_i,
  input  wire logic [WIDTH-1:0] taps_i,
  input  wire logic             load_i,
  input  wire logic [WIDTH-1:0] load_value_i,
  output logic      [WIDTH-1:0] remainder_o
);
  initial begin
    if (WIDTH != 16) $error("crc_lfsr supports a width of 16 only");
  end

  logic [WIDTH-1:0] next_remainder;
  logic             feedback;

  // The top stage is chosen by the programmed length, so shorter polynomials use the low bits.
  assign feedback = remainder_o[len_i] ^ bit_i;

  always_comb begin
    next_remainder = remainder_o;
    for (int i = WIDTH - 1; i > 0; i--) begin
      next_remainder[i] = remainder_o[i-1] ^ (feedback & taps_i[i]);
    end
    next_remainder[0] = feedback;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      remainder_o <= '0;
    end else if (load_i) begin
      remainder_o <= load_value_i;
    end else if (shift_i) begin
      remainder_o <= next_remainder;
    end
  end
endmodule

// ==== crc_generator.sv ====
// Contract
// - FIFO holds eight words above length seven, sixteen otherwise.
// - A write reaching the top data byte increments the valid-word count.
// - Shifter starts when run is set and count nonzero, then runs until count is zero; decrements per word shifted.
// - One data bit per clock, so length-plus-one cycles per word.
// - Full flag at depth, empty flag at zero count.
// - A write while full wraps the count to zero, with no interrupt.
// - Interrupt pulses when the count falls from one to zero.
// - In sleep the block freezes and resumes from the same state; here only the shifter stops, register writes and FIFO pushes still land.
// - In idle it freezes only if stop-in-idle is set; events still pass.
// - Control layout: stop-in-idle, count, full, empty, run, length fields.
// - Clearing run lets the shifter finish the FIFO before stopping.
// - Length field is polynomial length minus one; sets width and depth.
// - Polynomial bits fifteen to one enable feedback; bit zero reads zero.
// - Term zero always applied, and the top term is implied.
//
// Top of the CRC generator with its Wishbone slave, word FIFO and serial shifter.
// Assumes sleep_i and idle_i come from the power controller on the same clock.
//
// The implementer's own choices: register access over Wishbone and the address map.
`timescale 1ns/1ps
module crc_generator #(
  parameter int MAX_DEPTH = 16
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [3:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  input  wire logic        sleep_i,
  input  wire logic        idle_i,
  output logic             irq_o
);
  initial begin
    if (MAX_DEPTH != crc_pkg::DEPTH_NARROW) $error("MAX_DEPTH must equal the narrow FIFO depth");
  end

  typedef enum logic [1:0] {
    SH_IDLE  = 2'b01,
    SH_SHIFT = 2'b10
  } shift_state_t;

  shift_state_t state;
  shift_state_t next_state;

  logic        stop_in_idle;
  logic        shift_run;
  logic [3:0]  poly_length_minus_one;
  logic [15:0] crc_polynomial_terms;
  logic [4:0]  valid_word_count;
  logic        fifo_full_flag;
  logic        fifo_empty_flag;
  logic [15:0] fifo_mem [MAX_DEPTH];
  logic [3:0]  wr_ptr;
  logic [3:0]  rd_ptr;
  logic [15:0] shift_word;
  logic [3:0]  bit_index;
  logic [15:0] crc_data_word;
  logic [15:0] write_stage;

  // Bus decode.
  wire         bus_req      = cyc_i & stb_i & ~ack_o;
  wire         bus_wr       = bus_req & we_i;
  wire         hit_control  = adr_i == crc_pkg::CONTROL_OFFSET;
  wire         hit_poly     = adr_i == crc_pkg::POLY_OFFSET;
  wire         hit_data     = adr_i == crc_pkg::DATA_OFFSET;
  wire         wide_word    = poly_length_minus_one > 4'(crc_pkg::WIDE_LEN_LIMIT);
  wire  [4:0]  fifo_depth   = wide_word ? 5'(crc_pkg::DEPTH_WIDE) : 5'(crc_pkg::DEPTH_NARROW);
  // The top byte of the data word decides when a word is complete.
  wire         top_byte_sel = wide_word ? sel_i[1] : sel_i[0];
  wire         data_push    = bus_wr & hit_data & top_byte_sel;

  // Sleep and stop-in-idle freeze the engine; register access stays alive.
  wire         frozen       = sleep_i | (idle_i & stop_in_idle);
  wire         at_last_bit  = bit_index == 4'h0;
  wire         pop_word     = state == SH_SHIFT && !frozen && at_last_bit;
  wire         start_word   = state == SH_IDLE && !frozen && shift_run && valid_word_count != 5'h00;
  wire         lfsr_shift   = state == SH_SHIFT && !frozen;
  wire         lfsr_bit     = shift_word[bit_index];

  // Low byte lanes fill the data word; bytes outside the polynomial width are simply ignored.
  always_comb begin
    write_stage = crc_data_word;
    if (sel_i[0]) begin
      write_stage[7:0] = dat_i[7:0];
    end
    if (sel_i[1]) begin
      write_stage[15:8] = dat_i[15:8];
    end
  end

  // Count moves up on a push and down when the last bit of a word leaves.
  logic [4:0] next_count;
  logic       count_to_zero;

  always_comb begin
    next_count = valid_word_count;
    if (data_push && fifo_full_flag) begin
      next_count = 5'h00;
    end else if (data_push && !pop_word) begin
      next_count = valid_word_count + 5'h01;
    end else if (!data_push && pop_word) begin
      next_count = valid_word_count - 5'h01;
    end
  end

  // Only a genuine drain from one produces the interrupt, a wrap on overflow does not.
  assign count_to_zero = pop_word && !data_push && valid_word_count == 5'h01;

  always_comb begin
    next_state = state;
    unique case (state)
      SH_IDLE: begin
        if (start_word) begin
          next_state = SH_SHIFT;
        end
      end
      SH_SHIFT: begin
        // Run is only checked before shifting starts, so clearing it lets the FIFO drain.
        // A wrap on overflow also empties the FIFO, which stops the shifter without underflow.
        if (next_count == 5'h00) begin
          next_state = SH_IDLE;
        end
      end
      default: next_state = SH_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= SH_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stop_in_idle          <= crc_pkg::CONTROL_RESET[crc_pkg::STOP_IDLE_BIT];
      shift_run             <= crc_pkg::CONTROL_RESET[crc_pkg::RUN_BIT];
      poly_length_minus_one <= crc_pkg::CONTROL_RESET[crc_pkg::LEN_MSB:0];
      crc_polynomial_terms  <= crc_pkg::POLY_RESET;
    end else if (bus_wr && hit_control && sel_i[1] && sel_i[0]) begin
      stop_in_idle          <= dat_i[crc_pkg::STOP_IDLE_BIT];
      shift_run             <= dat_i[crc_pkg::RUN_BIT];
      poly_length_minus_one <= dat_i[crc_pkg::LEN_MSB:0];
    end else if (bus_wr && hit_control && sel_i[0]) begin
      shift_run             <= dat_i[crc_pkg::RUN_BIT];
      poly_length_minus_one <= dat_i[crc_pkg::LEN_MSB:0];
    end else if (bus_wr && hit_control && sel_i[1]) begin
      stop_in_idle          <= dat_i[crc_pkg::STOP_IDLE_BIT];
    end else if (bus_wr && hit_poly) begin
      if (sel_i[0]) begin
        crc_polynomial_terms[7:0] <= dat_i[7:0] & crc_pkg::POLY_MASK[7:0];
      end
      if (sel_i[1]) begin
        crc_polynomial_terms[15:8] <= dat_i[15:8];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      valid_word_count <= 5'h00;
      fifo_full_flag   <= crc_pkg::CONTROL_RESET[crc_pkg::FULL_BIT];
      fifo_empty_flag  <= crc_pkg::CONTROL_RESET[crc_pkg::EMPTY_BIT];
      wr_ptr           <= 4'h0;
      rd_ptr           <= 4'h0;
      irq_o            <= 1'b0;
    end else begin
      valid_word_count <= next_count;
      fifo_full_flag   <= next_count == fifo_depth;
      fifo_empty_flag  <= next_count == 5'h00;
      irq_o            <= count_to_zero;
      if (data_push && fifo_full_flag) begin
        wr_ptr <= 4'h0;
        rd_ptr <= 4'h0;
      end else begin
        if (data_push) begin
          wr_ptr <= (wr_ptr + 4'h1) & 4'(fifo_depth - 5'h01);
        end
        if (pop_word) begin
          rd_ptr <= (rd_ptr + 4'h1) & 4'(fifo_depth - 5'h01);
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (data_push) begin
      fifo_mem[wr_ptr] <= write_stage;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      crc_data_word <= 16'h0000;
      shift_word    <= 16'h0000;
      bit_index     <= 4'h0;
    end else begin
      if (bus_wr && hit_data) begin
        crc_data_word <= write_stage;
      end
      if (start_word || (pop_word && next_state == SH_SHIFT)) begin
        shift_word <= fifo_mem[start_word ? rd_ptr : (rd_ptr + 4'h1) & 4'(fifo_depth - 5'h01)];
        bit_index  <= poly_length_minus_one;
      end else if (lfsr_shift) begin
        bit_index  <= bit_index - 4'h1;
      end
    end
  end

  logic [15:0] remainder;

  crc_lfsr #(
    .WIDTH (16)
  ) engine (
    .clk_i        (clk_i),
    .rst_i        (rst_i),
    .shift_i      (lfsr_shift),
    .bit_i        (lfsr_bit),
    .len_i        (poly_length_minus_one),
    .taps_i       (crc_polynomial_terms),
    .load_i       (1'b0),
    .load_value_i (16'h0000),
    .remainder_o  (remainder)
  );

  // Read mux; the data register returns the remainder, valid once the FIFO is empty.
  wire [15:0] control_view = {2'b00, stop_in_idle, valid_word_count, fifo_full_flag, fifo_empty_flag,
                              1'b0, shift_run, poly_length_minus_one};
  wire [15:0] read_value   = hit_control ? control_view :
                             hit_poly    ? crc_polynomial_terms :
                             hit_data    ? remainder : 16'h0000;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h00000000;
    end else begin
      ack_o <= bus_req;
      if (bus_req && !we_i) begin
        dat_o <= {16'h0000, read_value};
      end
    end
  end
endmodule

// ==== crc_generator_assertions.sv ====
// Checker for the bus and event ports of the CRC generator.
// Assumes it is bound to crc_generator and sees only its ports.
`timescale 1ns/1ps
module crc_generator_assertions (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        we_i,
  input wire logic [3:0]  adr_i,
  input wire logic [3:0]  sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic        ack_o,
  input wire logic        sleep_i,
  input wire logic        idle_i,
  input wire logic        irq_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire rd     = cyc_i && stb_i && !we_i && !ack_o;
  wire rd_ctl = rd && adr_i == crc_pkg::CONTROL_OFFSET;
  wire mapped = adr_i inside {crc_pkg::CONTROL_OFFSET, crc_pkg::POLY_OFFSET, crc_pkg::DATA_OFFSET};
  ack_resp_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("request not acknowledged next cycle");
  ack_pulse_a: assert property (ack_o |=> !ack_o)
    else $error("ack held longer than one cycle");
  ack_cause_a: assert property (ack_o |-> $past(cyc_i && stb_i))
    else $error("ack without a request");
  irq_pulse_a: assert property (irq_o |=> !irq_o)
    else $error("interrupt held longer than one cycle");
  poly_bit0_a: assert property (rd && adr_i == crc_pkg::POLY_OFFSET |=> !dat_o[0])
    else $error("polynomial bit zero reads one");
  ctl_unused_a: assert property (rd_ctl |=> dat_o[31:14] == 18'h0 && !dat_o[5])
    else $error("unused control bits read nonzero");
  empty_flag_a: assert property (rd_ctl |=> dat_o[6] == (dat_o[12:8] == 5'h00))
    else $error("empty flag disagrees with count");
  full_flag_a: assert property (rd_ctl |=> dat_o[7] == (dat_o[12:8] == (dat_o[3:0] > 4'h7 ? 5'h08 : 5'h10)))
    else $error("full flag disagrees with count and depth");
  unmapped_read_a: assert property (rd && !mapped |=> dat_o == 32'h0)
    else $error("unmapped address reads nonzero");
  cover property (irq_o);
  cover property (rd_ctl ##1 dat_o[7]);
  cover property (ack_o && we_i && adr_i == crc_pkg::DATA_OFFSET);
endmodule

bind crc_generator crc_generator_assertions u_chk (
  .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
  .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .sleep_i(sleep_i),
  .idle_i(idle_i), .irq_o(irq_o));

// ==== testbench.sv ====
// Self-checking bench for the CRC generator through its Wishbone port.
// Assumes a 100 MHz clock and a synchronous active-high reset.
`timescale 1ns/1ps
module testbench;
  localparam logic [3:0] A_CTL = crc_pkg::CONTROL_OFFSET;
  localparam logic [3:0] A_DAT = crc_pkg::DATA_OFFSET;
  localparam logic [3:0] A_PLY = crc_pkg::POLY_OFFSET;
  typedef struct {string nm; logic [31:0] ex; logic [31:0] mk;} note_t;
  logic        clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, sleep_i = 0, idle_i = 0;
  logic [3:0]  adr_i = 4'h0, sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0;
  wire  [31:0] dat_o;
  wire         ack_o, irq_o;
  note_t       notes[$];
  int          err_total = 0, n_compared = 0, irq_cnt = 0, seed = 50;
  logic [15:0] crc = 16'h0000;
  logic [15:0] wd;
  crc_generator u_crc_generator (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .sleep_i(sleep_i), .idle_i(idle_i), .irq_o(irq_o));
  initial forever #5 clk_i = ~clk_i;
  task automatic chk(string nm, logic [31:0] ex, logic [31:0] got);
    n_compared++;
    if (got !== ex) begin
      err_total++;
      $display("FAIL %s expected %h seen %h", nm, ex, got);
    end
  endtask
  // Read data is judged at the ack edge, while we_i still qualifies the request.
  always @(posedge clk_i) begin
    if (irq_o === 1'b1) irq_cnt++;
    if (ack_o === 1'b1 && we_i === 1'b0) begin
      note_t n;
      n = notes.pop_front();
      chk(n.nm, n.ex, dat_o & n.mk);
    end
  end
  task automatic wb(logic w, logic [3:0] a, logic [3:0] s, logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk_i);
    {cyc_i, stb_i, we_i, adr_i, sel_i, dat_i} <= {2'b11, w, a, s, d};
    do begin
      @(posedge clk_i);
      k++;
    end while (ack_o !== 1'b1 && k < 100);
    if (k >= 100) begin
      err_total++;
      print_verdict();
    end
    {cyc_i, stb_i} <= 2'b00;
  endtask
  task automatic rd(string nm, logic [3:0] a, logic [31:0] ex, logic [31:0] mk);
    notes.push_back('{nm, ex & mk, mk});
    wb(1'b0, a, 4'h3, 32'h0);
  endtask
  task automatic ctl(logic run, logic [3:0] len, logic sidl);
    wb(1'b1, A_CTL, 4'h3, {18'h0, sidl, 8'h00, run, len});
  endtask
  task automatic push(logic [15:0] w, logic [3:0] s);
    wb(1'b1, A_DAT, s, {16'h0, w});
  endtask
  // The cycle count tolerates a few cycles of pipeline at start and end.
  task automatic wait_irq(int target, output int c);
    c = 0;
    while (irq_cnt < target && c < 3000) begin
      @(posedge clk_i);
      c++;
    end
  endtask
  function automatic logic [15:0] step(logic [15:0] r, logic [15:0] w);
    logic fb;
    for (int i = 15; i >= 0; i--) begin
      fb = w[i] ^ r[15];
      r = {r[14:0], 1'b0} ^ (fb ? 16'h1021 : 16'h0000);
    end
    return r;
  endfunction
  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    #100us;
    err_total++;
    print_verdict();
  end
  initial begin
    int c;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    rd("control reset", A_CTL, {16'h0, crc_pkg::CONTROL_RESET}, 32'hFFFFFFFF);
    rd("poly reset", A_PLY, 32'h0, 32'hFFFFFFFF);
    rd("unmapped read", 4'hC, 32'h0, 32'hFFFFFFFF);
    wb(1'b1, A_PLY, 4'h3, 32'h0000FFFF);
    rd("poly terms", A_PLY, 32'h0000FFFE, 32'hFFFFFFFF);
    wb(1'b1, A_PLY, 4'h3, 32'h00001021);
    $display("test registers done");
    ctl(1'b0, 4'hF, 1'b0);
    push(16'h00AA, 4'h1);
    rd("low lane count", A_CTL, 32'h0040, 32'h1FC0);
    repeat (8) begin
      wd = 16'($random(seed));
      push(wd, 4'h3);
      crc = step(crc, wd);
    end
    rd("wide full", A_CTL, 32'h0880, 32'h1FC0);
    ctl(1'b1, 4'hF, 1'b0);
    ctl(1'b0, 4'hF, 1'b0);
    wait_irq(1, c);
    chk("shift cycles", 32'h1, {31'h0, c inside {[118:134]}});
    chk("drain irq", 32'h1, irq_cnt);
    rd("drained", A_CTL, 32'h004F, 32'h1FDF);
    rd("crc result", A_DAT, {16'h0, crc}, 32'hFFFF);
    $display("test wide drain done");
    sleep_i <= 1'b1;
    ctl(1'b0, 4'h7, 1'b1);
    push(16'($random(seed)), 4'h1);
    push(16'($random(seed)), 4'h1);
    ctl(1'b1, 4'h7, 1'b1);
    repeat (30) @(posedge clk_i);
    rd("sleep frozen", A_CTL, 32'h2217, 32'h3FDF);
    sleep_i <= 1'b0;
    idle_i <= 1'b1;
    repeat (30) @(posedge clk_i);
    rd("idle frozen", A_CTL, 32'h2217, 32'h3FDF);
    ctl(1'b1, 4'h7, 1'b0);
    wait_irq(2, c);
    chk("idle runs", 32'h2, irq_cnt);
    $display("test power save done");
    idle_i <= 1'b0;
    ctl(1'b0, 4'h7, 1'b0);
    repeat (16) push(16'($random(seed)), 4'h1);
    rd("narrow full", A_CTL, 32'h1087, 32'h1FDF);
    push(16'h005A, 4'h1);
    rd("wrap count", A_CTL, 32'h0047, 32'h1FDF);
    repeat (5) @(posedge clk_i);
    chk("no wrap irq", 32'h2, irq_cnt);
    $display("test wrap done");
    print_verdict();
  end
endmodule
